// *** hdl/pgm_regs.svh ***
// pgm_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the power-good monitor top module
`ifndef PGM_REGS_SVH
`define PGM_REGS_SVH

// word byte addresses on the wishbone slave
`define PGM_CTRL_ADDR      8'h00
`define PGM_SELECT_ADDR    8'h04
`define PGM_WINDOW_ADDR    8'h08
`define PGM_ILIM_ADDR      8'h0c
`define PGM_DISCH_ADDR     8'h10
`define PGM_MASK_ADDR      8'h14
`define PGM_IRQ_ADDR       8'h18
`define PGM_FAULT_ADDR     8'h1c
`define PGM_STATUS_ADDR    8'h20

// control register fields
`define PGM_CTRL_POL_BIT   0
`define PGM_CTRL_OD_BIT    1
`define PGM_CTRL_GATE_BIT  2
`define PGM_CTRL_TWL_BIT   3

// interrupt register fields
`define PGM_IRQ_BILIM_LSB  0
`define PGM_IRQ_LILIM_LSB  2
`define PGM_IRQ_TWARN_BIT  4
`define PGM_IRQ_OVP_BIT    5
`define PGM_IRQ_TSD_BIT    6

// reset values
`define PGM_CTRL_RST       4'h0
`define PGM_SELECT_RST     5'h0f
`define PGM_WINDOW_RST     4'h0
`define PGM_ILIM_RST       6'h24
`define PGM_DISCH_RST      4'h0f
`define PGM_MASK_RST       5'h00

// timing: figures in ns, clock period in ns
`define PGM_CLK_PERIOD_NS  50
`define PGM_GATE_TIME_NS   800000
`define PGM_ILIM_TIME_NS   20000
`define PGM_DEB_TIME_NS    6000
`define PGM_GATE_CYC       (`PGM_GATE_TIME_NS / `PGM_CLK_PERIOD_NS)
`define PGM_ILIM_CYC       (`PGM_ILIM_TIME_NS / `PGM_CLK_PERIOD_NS)
`define PGM_DEB_CYC        (`PGM_DEB_TIME_NS / `PGM_CLK_PERIOD_NS)

`endif

// *** hdl/pgm_pkg.sv ***
// pgm_pkg.sv: types shared by the power-good monitor
// assumes: constants come from pgm_regs.svh
package pgm_pkg;

  // analogue comparator results for one rail
  typedef struct packed {
    logic uv_ok;     // above undervoltage threshold
    logic ov_ok;     // below overvoltage threshold
    logic enabled;   // regulator enabled
    logic ramping;   // moving between targets
    logic in_ilim;   // in current-limit regulation
  } pgm_rail_s;

  // gated-mode sequencer
  typedef enum logic [2:0] {
    PGM_ST_IDLE = 3'b001,
    PGM_ST_HOLD = 3'b010,
    PGM_ST_RUN  = 3'b100
  } pgm_state_e;

endpackage : pgm_pkg

// *** hdl/pgm_power_good_monitor.sv ***
// pgm_power_good_monitor.sv: power-good combiner, rail fault latches, interrupts
// assumes: classic wishbone master on REF_CLK_IN, comparator inputs already synchronous
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pgm_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// (RQ1) each rail voltage monitor has its own select bit; current limit never counts
// (RQ2) disabled regulators are masked out of the power-good combine
// (RQ3) thermal warning joins power-good only when its select bit is set
// (RQ4) power good needs all selected rails, warning, overvoltage and shutdown irqs valid
// (RQ5) window bit 0 checks undervoltage only, 1 checks both under and over
// (RQ6) polarity and open-drain bits shape the pin only, not internal sense
// (RQ7) mode bit 0 gated, 1 continuous; output starts active after load
// (RQ8) gated mode freezes power good 800 us after each step or change
// (RQ9) gated mode latches rail faults; monitoring waits until they are cleared
// (RQ10) host clears faults and irqs by writing one to their bits
// (RQ11) continuous mode goes inactive at enable then tracks regulation live
// (RQ12) continuous mode fault bits latch until host writes one
// (RQ13) power good is held inactive while any selected rail ramps between targets
// (RQ14) power good returns active when rails recover, unless fault gating is on
// (RQ15) with fault gating set, any pending fault bit keeps power good inactive
// (RQ16) each buck has a 3-bit current limit level field
// (RQ17) buck in current limit 20 us sets its irq and pulls the line low
// (RQ18) buck limit has live status, write-one-clear irq and mask bit
// (RQ19) linear regulator in current limit 20 us sets its irq and pulls line low
// (RQ20) linear regulator limit has live status, write-one-clear irq and mask bit
// (RQ21) die above selected warning threshold sets warning irq and live status
// (RQ22) warning irq clears on write one; its mask suppresses the line
// (RQ23) protective disable tri-states outputs; discharge only if its enable is set
// (RQ24) power-good output changes are filtered with a 6 us debounce
// (RQ25) shutdown irq clear is ignored while die stays above shutdown level
// (RQ26) irq line stays low while any unmasked irq is pending
module pgm_power_good_monitor #(
  parameter int NRAIL     = 4,                // buck 0,1 then linear 0,1
  parameter int GATE_CYC  = `PGM_GATE_CYC,
  parameter int ILIM_CYC  = `PGM_ILIM_CYC,
  parameter int DEB_CYC   = `PGM_DEB_CYC
) (
  input  wire logic                  REF_CLK_IN,
  input  wire logic                  RESET_N_IN,
  // wishbone classic slave
  input  wire logic                  WB_CYC_IN,
  input  wire logic                  WB_STB_IN,
  input  wire logic                  WB_WE_IN,
  input  wire logic [7:0]            WB_ADR_IN,
  input  wire logic [3:0]            WB_SEL_IN,
  input  wire logic [31:0]           WB_DAT_IN,
  output logic      [31:0]           WB_DAT_OUT,
  output logic                       WB_ACK_OUT,
  // analogue monitor results
  input  wire pgm_pkg::pgm_rail_s [NRAIL-1:0] RAIL_IN,
  input  wire logic                  CONTINUOUS_SEL_IN,   // otp mode bit
  input  wire logic                  CFG_LOADED_IN,       // otp load done
  input  wire logic                  SEQ_STEP_IN,         // sequence step or voltage change
  input  wire logic                  TEMP_WARN_LO_IN,     // above low warning level
  input  wire logic                  TEMP_WARN_HI_IN,     // above high warning level
  input  wire logic                  TEMP_SD_IN,          // above shutdown level
  input  wire logic                  INPUT_OV_IN,         // input overvoltage
  input  wire logic                  PROT_DISABLE_IN,     // protection disables all
  // pins and regulator controls
  output logic                       POWER_GOOD_OUT,
  output logic                       POWER_GOOD_OE_OUT,
  output logic                       IRQ_LINE_N_OUT,
  output logic                       IRQ_LINE_N_OE_OUT,
  output logic [NRAIL-1:0]           SWITCH_HIZ_OUT,
  output logic [NRAIL-1:0]           DISCHARGE_OUT,
  output logic [5:0]                 BUCK_LIMIT_LEVEL_OUT
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]       ctrl_q;
  logic [NRAIL:0]   select_q;          // rails then thermal warning
  logic [NRAIL-1:0] window_q;
  logic [5:0]       ilim_q;
  logic [NRAIL-1:0] disch_q;
  logic [NRAIL:0]   mask_q;            // limits then thermal warning
  logic [6:0]       irq_q;
  logic [6:0]       irq_d;
  logic [NRAIL-1:0] fault_q;
  logic [NRAIL-1:0] fault_d;
  logic             ack_q;
  logic [31:0]      rdat_q;

  // bus decode
  wire        wb_req   = WB_CYC_IN & WB_STB_IN & ~ack_q;
  wire        wb_wr    = wb_req & WB_WE_IN & WB_SEL_IN[0];
  wire        wr_ctrl  = wb_wr & (WB_ADR_IN == `PGM_CTRL_ADDR);
  wire        wr_sel   = wb_wr & (WB_ADR_IN == `PGM_SELECT_ADDR);
  wire        wr_win   = wb_wr & (WB_ADR_IN == `PGM_WINDOW_ADDR);
  wire        wr_ilim  = wb_wr & (WB_ADR_IN == `PGM_ILIM_ADDR);
  wire        wr_disch = wb_wr & (WB_ADR_IN == `PGM_DISCH_ADDR);
  wire        wr_mask  = wb_wr & (WB_ADR_IN == `PGM_MASK_ADDR);
  wire        wr_irq   = wb_wr & (WB_ADR_IN == `PGM_IRQ_ADDR);
  wire        wr_fault = wb_wr & (WB_ADR_IN == `PGM_FAULT_ADDR);
  wire [7:0]  wdat     = WB_DAT_IN[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // per-rail sense
  logic [NRAIL-1:0] rail_ok;
  logic [NRAIL-1:0] rail_ilim;
  logic [NRAIL-1:0] rail_en;
  logic [NRAIL-1:0] rail_ramp;
  logic [NRAIL-1:0] rail_bad;
  logic [NRAIL-1:0] ilim_hit;
  genvar g;
  generate
    for (g = 0; g < NRAIL; g++) begin : g_rail
      logic [15:0] ilim_cnt_q;
      assign rail_ok[g]   = RAIL_IN[g].uv_ok & (~window_q[g] | RAIL_IN[g].ov_ok); // RQ5
      assign rail_ilim[g] = RAIL_IN[g].in_ilim;
      assign rail_en[g]   = RAIL_IN[g].enabled;
      assign rail_ramp[g] = RAIL_IN[g].enabled & RAIL_IN[g].ramping;
      // selected, enabled, out of range; current limit plays no part
      assign rail_bad[g]  = select_q[g] & rail_en[g] & ~rail_ok[g]; // RQ1 RQ2
      // 20 us persistence of current-limit regulation
      always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          ilim_cnt_q <= 16'h0000;
        end else if (!rail_ilim[g]) begin
          ilim_cnt_q <= 16'h0000;
        end else if (ilim_cnt_q != 16'(ILIM_CYC)) begin
          ilim_cnt_q <= ilim_cnt_q + 16'h0001;
        end
      end
      assign ilim_hit[g] = rail_ilim[g] & (ilim_cnt_q == 16'(ILIM_CYC) - 16'h0001); // RQ17 RQ19
      // outputs float on protective disable, discharge only when allowed
      assign SWITCH_HIZ_OUT[g] = PROT_DISABLE_IN; // RQ23
      assign DISCHARGE_OUT[g]  = PROT_DISABLE_IN & disch_q[g]; // RQ23
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // interrupt flags; a new event wins over a clear in the same cycle
  wire twarn_live = ctrl_q[`PGM_CTRL_TWL_BIT] ? TEMP_WARN_HI_IN : TEMP_WARN_LO_IN; // RQ21
  wire [6:0] irq_set = {TEMP_SD_IN, INPUT_OV_IN, twarn_live, ilim_hit[3:2], ilim_hit[1:0]};
  // clears of level-held sources are refused while the cause persists
  wire [6:0] irq_hold = {TEMP_SD_IN, INPUT_OV_IN, twarn_live, 4'h0}; // RQ25
  wire [6:0] irq_clr  = wr_irq ? (wdat[6:0] & ~irq_hold) : 7'h00; // RQ10 RQ18 RQ20 RQ22
  assign irq_d = (irq_q & ~irq_clr) | irq_set; // RQ17 RQ19 RQ21

  // shutdown and overvoltage are never masked from the line
  wire irq_any = |(irq_q & ~{2'b00, mask_q}); // RQ18 RQ20 RQ22 RQ26
  assign IRQ_LINE_N_OUT    = 1'b0; // open drain, only ever pulls low
  assign IRQ_LINE_N_OE_OUT = irq_any; // RQ26

  //////////////////////////////////////////////////////////////////////////////
  // power-good combine and mode handling
  pgm_pkg::pgm_state_e st_q;
  pgm_pkg::pgm_state_e st_d;
  logic [15:0] gate_cnt_q;
  logic        pg_raw_q;            // internal valid sense, before debounce
  logic        pg_q;                // debounced valid sense
  logic [15:0] deb_cnt_q;
  logic        cont_q;              // mode caught after otp load

  wire twarn_bad  = select_q[NRAIL] & twarn_live; // RQ3
  wire sys_bad    = irq_q[`PGM_IRQ_OVP_BIT] | irq_q[`PGM_IRQ_TSD_BIT] | twarn_bad; // RQ4
  wire any_bad    = (|rail_bad) | sys_bad; // RQ4
  wire any_ramp   = |(rail_ramp & select_q[NRAIL-1:0]); // RQ13
  wire fault_gate = ctrl_q[`PGM_CTRL_GATE_BIT] & (|fault_q); // RQ15
  wire gate_done  = (gate_cnt_q == 16'(GATE_CYC));

  assign fault_d = (fault_q & ~(wr_fault ? wdat[NRAIL-1:0] : '0)) | rail_bad; // RQ9 RQ12

  // gated mode sequencer: hold after each step, then judge
  always_comb begin
    st_d = st_q;
    case (st_q)
      pgm_pkg::PGM_ST_IDLE: if (CFG_LOADED_IN) st_d = pgm_pkg::PGM_ST_RUN;
      pgm_pkg::PGM_ST_HOLD: if (gate_done) st_d = pgm_pkg::PGM_ST_RUN; // RQ8
      pgm_pkg::PGM_ST_RUN:  if (SEQ_STEP_IN) st_d = pgm_pkg::PGM_ST_HOLD; // RQ8
      default:              st_d = pgm_pkg::PGM_ST_IDLE;
    endcase
  end

  // continuous: inactive while a monitored rail ramps or is out; gated: judge outside hold,
  // and stay low until faults are cleared so monitoring does not resume early
  wire pg_cont  = ~any_bad & ~any_ramp & ~fault_gate; // RQ11 RQ13 RQ14 RQ15
  wire pg_gated = ~any_bad & ~(|fault_q) & ~any_ramp; // RQ9 RQ13
  wire pg_eval  = cont_q ? pg_cont : pg_gated; // RQ7
  // the step's own cycle is frozen too, so a rail dropping with the step is not judged early
  wire pg_frz   = ~cont_q & ((st_q != pgm_pkg::PGM_ST_RUN) | SEQ_STEP_IN); // RQ8

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_q       <= pgm_pkg::PGM_ST_IDLE;
      gate_cnt_q <= 16'h0000;
      cont_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      gate_cnt_q <= (st_q == pgm_pkg::PGM_ST_HOLD && !gate_done) ? gate_cnt_q + 16'h0001
                                                                  : 16'h0000;
      if (st_q == pgm_pkg::PGM_ST_IDLE && CFG_LOADED_IN) cont_q <= CONTINUOUS_SEL_IN; // RQ7
    end
  end

  // raw sense starts active (RQ7); debounce needs DEB_CYC of steady change
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pg_raw_q  <= 1'b1; // RQ7
      pg_q      <= 1'b1;
      deb_cnt_q <= 16'h0000;
    end else begin
      if (st_q != pgm_pkg::PGM_ST_IDLE && !pg_frz) pg_raw_q <= pg_eval;
      if (pg_raw_q == pg_q) begin
        deb_cnt_q <= 16'h0000;
      end else if (deb_cnt_q == 16'(DEB_CYC) - 16'h0001) begin
        pg_q      <= pg_raw_q; // RQ24
        deb_cnt_q <= 16'h0000;
      end else begin
        deb_cnt_q <= deb_cnt_q + 16'h0001;
      end
    end
  end

  // polarity only flips the pin; open drain drives only the low level
  wire pin_lvl = pg_q ^ ctrl_q[`PGM_CTRL_POL_BIT]; // RQ6
  assign POWER_GOOD_OUT    = pin_lvl;
  assign POWER_GOOD_OE_OUT = ~ctrl_q[`PGM_CTRL_OD_BIT] | ~pin_lvl; // RQ6
  assign BUCK_LIMIT_LEVEL_OUT = ilim_q; // RQ16

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl_q   <= `PGM_CTRL_RST;
      select_q <= `PGM_SELECT_RST;
      window_q <= `PGM_WINDOW_RST;
      ilim_q   <= `PGM_ILIM_RST;
      disch_q  <= `PGM_DISCH_RST;
      mask_q   <= `PGM_MASK_RST;
      irq_q    <= 7'h00;
      fault_q  <= 4'h0;
    end else begin
      if (wr_ctrl)  ctrl_q   <= wdat[3:0];
      if (wr_sel)   select_q <= wdat[NRAIL:0]; // RQ1 RQ3
      if (wr_win)   window_q <= wdat[NRAIL-1:0];
      if (wr_ilim)  ilim_q   <= wdat[5:0]; // RQ16
      if (wr_disch) disch_q  <= wdat[NRAIL-1:0];
      if (wr_mask)  mask_q   <= wdat[NRAIL:0];
      irq_q   <= irq_d;
      fault_q <= fault_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero and still ack
  wire [31:0] status_w = {24'h000000, pg_q, TEMP_SD_IN, INPUT_OV_IN, twarn_live,
                          rail_ilim}; // RQ18 RQ20 RQ21
  wire [31:0] rd_mux =
    (WB_ADR_IN == `PGM_CTRL_ADDR)   ? {28'h0000000, ctrl_q}  :
    (WB_ADR_IN == `PGM_SELECT_ADDR) ? {27'h0000000, select_q} :
    (WB_ADR_IN == `PGM_WINDOW_ADDR) ? {28'h0000000, window_q} :
    (WB_ADR_IN == `PGM_ILIM_ADDR)   ? {26'h0000000, ilim_q}  :
    (WB_ADR_IN == `PGM_DISCH_ADDR)  ? {28'h0000000, disch_q} :
    (WB_ADR_IN == `PGM_MASK_ADDR)   ? {27'h0000000, mask_q}  :
    (WB_ADR_IN == `PGM_IRQ_ADDR)    ? {25'h0000000, irq_q}   :
    (WB_ADR_IN == `PGM_FAULT_ADDR)  ? {28'h0000000, fault_q} :
    (WB_ADR_IN == `PGM_STATUS_ADDR) ? status_w : 32'h00000000;

  // one wait-free cycle: ack the edge after the request, drop it next cycle
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= wb_req;
      rdat_q <= wb_req ? rd_mux : rdat_q;
    end
  end
  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdat_q;

endmodule // pgm_power_good_monitor

`default_nettype wire

// *** sim/pgm_monitor_assertions.sv ***
// checker for the power-good monitor top-level ports
// assumes: bound into pgm_power_good_monitor, one clock domain
`timescale 1ns/10ps
`default_nettype none
module pgm_monitor_assertions #(
  parameter int NRAIL    = 4,
  parameter int GATE_CYC = 20,
  parameter int ILIM_CYC = 8,
  parameter int DEB_CYC  = 4
) (
  input wire logic                            REF_CLK_IN,
  input wire logic                            RESET_N_IN,
  input wire logic                            WB_CYC_IN,
  input wire logic                            WB_STB_IN,
  input wire logic                            WB_WE_IN,
  input wire logic [7:0]                      WB_ADR_IN,
  input wire logic [3:0]                      WB_SEL_IN,
  input wire logic [31:0]                     WB_DAT_IN,
  input wire logic                            WB_ACK_OUT,
  input wire pgm_pkg::pgm_rail_s [NRAIL-1:0]  RAIL_IN,
  input wire logic                            CFG_LOADED_IN,
  input wire logic                            SEQ_STEP_IN,
  input wire logic                            TEMP_SD_IN,
  input wire logic                            PROT_DISABLE_IN,
  input wire logic                            POWER_GOOD_OUT,
  input wire logic                            POWER_GOOD_OE_OUT,
  input wire logic                            IRQ_LINE_N_OUT,
  input wire logic                            IRQ_LINE_N_OE_OUT,
  input wire logic [NRAIL-1:0]                SWITCH_HIZ_OUT,
  input wire logic [NRAIL-1:0]                DISCHARGE_OUT,
  input wire logic [5:0]                      BUCK_LIMIT_LEVEL_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of polarity and buck0 mask, plus hold counters
  wire  wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT && WB_SEL_IN[0];
  logic pol_q;
  logic msk_q;
  int   sd_q;
  int   il_q;
  // counters saturate so long runs never wrap
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pol_q <= 1'b0;
      msk_q <= 1'b0;
      sd_q  <= 0;
      il_q  <= 0;
    end else begin
      if (wr && WB_ADR_IN == 8'h00) pol_q <= WB_DAT_IN[0];
      if (wr && WB_ADR_IN == 8'h14) msk_q <= WB_DAT_IN[0];
      sd_q <= (TEMP_SD_IN && CFG_LOADED_IN && !SEQ_STEP_IN) ? sd_q + (sd_q < 5000) : 0;
      il_q <= RAIL_IN[0].in_ilim ? il_q + (il_q < 5000) : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |-> ##1 WB_ACK_OUT)
    else $error("request not acknowledged next cycle");
  a_ack_one_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("acknowledge longer than one cycle");
  a_limit_level_write: assert property ((wr && WB_ADR_IN == 8'h0c) |=>
    BUCK_LIMIT_LEVEL_OUT == $past(WB_DAT_IN[5:0])) else $error("limit level not written");
  a_hiz_on_protect: assert property (SWITCH_HIZ_OUT == {NRAIL{PROT_DISABLE_IN}})
    else $error("switches not high impedance on protective disable");
  a_discharge_needs_hiz: assert property ((DISCHARGE_OUT & ~SWITCH_HIZ_OUT) == '0)
    else $error("discharge without disable");
  a_irq_pin_low: assert property (IRQ_LINE_N_OUT == 1'b0)
    else $error("interrupt line driven high");
  a_od_release_high: assert property (!POWER_GOOD_OE_OUT |-> POWER_GOOD_OUT)
    else $error("power good released while low");
  a_tsd_pg_inactive: assert property ((sd_q > GATE_CYC + DEB_CYC + 4) |->
    POWER_GOOD_OUT == pol_q) else $error("power good active in shutdown");
  a_ilim_pulls_line: assert property ((il_q > ILIM_CYC + 2 && !msk_q) |->
    IRQ_LINE_N_OE_OUT) else $error("current limit did not pull interrupt line");
endmodule // pgm_monitor_assertions

bind pgm_power_good_monitor pgm_monitor_assertions #(.NRAIL(NRAIL), .GATE_CYC(GATE_CYC),
  .ILIM_CYC(ILIM_CYC), .DEB_CYC(DEB_CYC)) u_chk (.REF_CLK_IN(REF_CLK_IN),
  .RESET_N_IN(RESET_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
  .WB_ACK_OUT(WB_ACK_OUT), .RAIL_IN(RAIL_IN), .CFG_LOADED_IN(CFG_LOADED_IN),
  .SEQ_STEP_IN(SEQ_STEP_IN), .TEMP_SD_IN(TEMP_SD_IN), .PROT_DISABLE_IN(PROT_DISABLE_IN),
  .POWER_GOOD_OUT(POWER_GOOD_OUT), .POWER_GOOD_OE_OUT(POWER_GOOD_OE_OUT),
  .IRQ_LINE_N_OUT(IRQ_LINE_N_OUT), .IRQ_LINE_N_OE_OUT(IRQ_LINE_N_OE_OUT),
  .SWITCH_HIZ_OUT(SWITCH_HIZ_OUT), .DISCHARGE_OUT(DISCHARGE_OUT),
  .BUCK_LIMIT_LEVEL_OUT(BUCK_LIMIT_LEVEL_OUT));
`default_nettype wire

// *** sim/pgm_host_model.sv ***
// host-side board model: pull-ups on the power-good and interrupt wires
// assumes: pin levels and enables come straight from the monitor
`timescale 1ns/10ps
`default_nettype none
module pgm_host_model (
  input  wire logic pg_level_in,
  input  wire logic pg_oe_in,
  input  wire logic irq_level_in,
  input  wire logic irq_oe_in,
  output logic      pg_wire_out,
  output logic      irq_wire_n_out
);
  // released wires float up, so open drain reads high when let go
  assign pg_wire_out    = pg_oe_in ? pg_level_in : 1'b1;
  assign irq_wire_n_out = irq_oe_in ? irq_level_in : 1'b1;
endmodule // pgm_host_model
`default_nettype wire

// *** sim/pgm_power_good_monitor_test.sv ***
// testbench for the power-good monitor: wishbone tasks plus pin checks
// assumes: short timing parameters, host model resolving the pins
`timescale 1ns/10ps
`default_nettype none
module pgm_power_good_monitor_test;
  localparam int GC = 20;
  localparam int IC = 8;
  localparam int DC = 4;
  logic clk, rst_n, cyc, stb, we, cont, cfg, step, twlo, twhi, tsd, ov, prot;
  logic ack, pg, pg_oe, irq, irq_oe, pg_w, irq_w;
  logic [7:0]  adr;
  logic [3:0]  sel, hiz, dis;
  logic [31:0] dw, dr, rd;
  logic [5:0]  lim;
  pgm_pkg::pgm_rail_s [3:0] rail;
  int mismatches, samples_checked, cycles;
  logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [31:0] rv [9] = '{32'h0, 32'h0f, 32'h0, 32'h24, 32'h0f, 32'h0, 32'h0, 32'h0, 32'h0};

  pgm_power_good_monitor #(.GATE_CYC(GC), .ILIM_CYC(IC), .DEB_CYC(DC)) DUT (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dw), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack),
    .RAIL_IN(rail), .CONTINUOUS_SEL_IN(cont), .CFG_LOADED_IN(cfg), .SEQ_STEP_IN(step),
    .TEMP_WARN_LO_IN(twlo), .TEMP_WARN_HI_IN(twhi), .TEMP_SD_IN(tsd), .INPUT_OV_IN(ov),
    .PROT_DISABLE_IN(prot), .POWER_GOOD_OUT(pg), .POWER_GOOD_OE_OUT(pg_oe),
    .IRQ_LINE_N_OUT(irq), .IRQ_LINE_N_OE_OUT(irq_oe), .SWITCH_HIZ_OUT(hiz),
    .DISCHARGE_OUT(dis), .BUCK_LIMIT_LEVEL_OUT(lim));
  pgm_host_model u_host (.pg_level_in(pg), .pg_oe_in(pg_oe), .irq_level_in(irq),
    .irq_oe_in(irq_oe), .pg_wire_out(pg_w), .irq_wire_n_out(irq_w));
  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and a hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycle and settle helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until ack is sampled high, then one idle cycle
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) check({31'h0, ack}, 32'h1);
    rd = dr;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    check(rd, e);
  endtask
  // waits out the pin debounce before looking
  task automatic pgchk(input logic e);
    repeat (DC + 8) @(posedge clk);
    check({31'h0, pg_w}, {31'h0, e});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence, continuous mode first, then gated after a second reset
  initial begin
    {cyc, stb, we, step, twlo, twhi, tsd, ov, prot, cfg} = '0;
    adr = 8'h00; dw = 32'h0; sel = 4'hf; cont = 1'b1; rst_n = 1'b0;
    rail = {4{5'b11100}}; mismatches = 0; samples_checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1; cfg <= 1'b1;
    foreach (ra[i]) rdchk(ra[i], rv[i]);
    check({26'h0, lim}, 32'h24);
    wr(8'h0c, 32'h3d); rdchk(8'h0c, 32'h3d); check({26'h0, lim}, 32'h3d);
    $display("done: registers");
    for (int i = 0; i < 4; i++) begin
      rail[i].in_ilim <= 1'b1; repeat (IC + 4) @(posedge clk);
      rdchk(8'h20, 32'h80 | (32'h1 << i));
      rdchk(8'h18, 32'h1 << i); check({31'h0, irq_w}, 32'h0);
      rail[i].in_ilim <= 1'b0; wr(8'h18, 32'h1 << i);
      rdchk(8'h18, 32'h0); check({31'h0, irq_w}, 32'h1);
    end
    wr(8'h14, 32'ha); rail[1].in_ilim <= 1'b1; rail[3].in_ilim <= 1'b1;
    repeat (IC + 4) @(posedge clk);
    rdchk(8'h18, 32'ha); check({31'h0, irq_w}, 32'h1);
    rail[1].in_ilim <= 1'b0; rail[3].in_ilim <= 1'b0; wr(8'h18, 32'ha); wr(8'h14, 32'h0);
    $display("done: current limit");
    wr(8'h00, 32'h8); wr(8'h14, 32'h10); twlo <= 1'b1; repeat (IC) @(posedge clk);
    rdchk(8'h18, 32'h0);
    twhi <= 1'b1; repeat (IC) @(posedge clk);
    rdchk(8'h18, 32'h10); check({31'h0, irq_w}, 32'h1);
    wr(8'h14, 32'h0); wr(8'h00, 32'h0);
    twlo <= 1'b1; twhi <= 1'b1; repeat (IC + DC + 8) @(posedge clk);
    rdchk(8'h18, 32'h10); check({31'h0, irq_w}, 32'h0); pgchk(1'b1);
    wr(8'h04, 32'h1f); pgchk(1'b0);
    wr(8'h18, 32'h10); rdchk(8'h18, 32'h10);
    twlo <= 1'b0; twhi <= 1'b0; repeat (IC + DC + 8) @(posedge clk);
    wr(8'h18, 32'h10); rdchk(8'h18, 32'h0); wr(8'h04, 32'h0f); pgchk(1'b1);
    $display("done: thermal warning");
    rail[2].uv_ok <= 1'b0; pgchk(1'b0); rdchk(8'h1c, 32'h4);
    rail[2].uv_ok <= 1'b1; pgchk(1'b1); rdchk(8'h1c, 32'h4);
    wr(8'h1c, 32'h4); rdchk(8'h1c, 32'h0);
    wr(8'h04, 32'h0b); rail[2].uv_ok <= 1'b0; pgchk(1'b1);
    rail[2].uv_ok <= 1'b1; wr(8'h04, 32'h0f);
    rail[3].enabled <= 1'b0; rail[3].uv_ok <= 1'b0; pgchk(1'b1);
    rail[3] <= 5'b11100; rail[1].ov_ok <= 1'b0; pgchk(1'b1);
    wr(8'h08, 32'h2); pgchk(1'b0);
    wr(8'h08, 32'h0); rail[1].ov_ok <= 1'b1; rail[0].ramping <= 1'b1; pgchk(1'b0);
    rail[0].ramping <= 1'b0; wr(8'h1c, 32'hf); pgchk(1'b1);
    wr(8'h00, 32'h4); rail[0].uv_ok <= 1'b0; pgchk(1'b0);
    rail[0].uv_ok <= 1'b1; pgchk(1'b0);
    wr(8'h1c, 32'hf); pgchk(1'b1); wr(8'h00, 32'h0);
    $display("done: rail monitors");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) tsd <= 1'b1;
      else ov <= 1'b1;
      pgchk(1'b0); repeat (GC) @(posedge clk);
      wr(8'h18, 32'h40 >> k); rdchk(8'h18, 32'h40 >> k);
      tsd <= 1'b0; ov <= 1'b0; repeat (IC + DC + 8) @(posedge clk);
      wr(8'h18, 32'h40 >> k); pgchk(1'b1);
    end
    $display("done: shutdown and overvoltage");
    wr(8'h00, 32'h1); pgchk(1'b0);
    wr(8'h00, 32'h3); pgchk(1'b0); check({31'h0, pg_oe}, 32'h1);
    wr(8'h00, 32'h2); pgchk(1'b1); check({31'h0, pg_oe}, 32'h0);
    wr(8'h00, 32'h0); wr(8'h10, 32'h5); prot <= 1'b1; repeat (2) @(posedge clk);
    check({28'h0, hiz}, 32'hf); check({28'h0, dis}, 32'h5);
    prot <= 1'b0;
    $display("done: pins and protection");
    cont <= 1'b0; cfg <= 1'b0; rst_n <= 1'b0; repeat (2) @(posedge clk);
    rst_n <= 1'b1; cfg <= 1'b1; repeat (2) @(posedge clk);
    check({31'h0, pg_w}, 32'h1);
    rail[0].uv_ok <= 1'b0; step <= 1'b1; @(posedge clk);
    step <= 1'b0; repeat (GC - 4) @(posedge clk);
    check({31'h0, pg_w}, 32'h1);
    repeat (GC) @(posedge clk); pgchk(1'b0);
    rail[0].uv_ok <= 1'b1; pgchk(1'b0); rdchk(8'h1c, 32'h1);
    wr(8'h1c, 32'h1); pgchk(1'b1);
    $display("done: gated mode");
    end_of_test();
  end
endmodule // pgm_power_good_monitor_test
`default_nettype wire
